// File: core/rrd_top.sv
// Purpose: Rotate and round datapath slice behind an AHB-Lite port.
// Assumes: Single-word transfers on sys_clk; the slave never waits.
// Notes:   One operation step per clock; repeats run back to back.
//
// How it works
// - Rotate right shifts toward bit 0; new bit on top, bit 0 out.
// - Test flag 2 or carry chosen freely as input and output bit.
// - 16-bit source into accumulator is zero-extended to 40 bits.
// - Accumulator right rotate is 40-bit; input position per wide mode.
// - Register destination uses low 16 bits; in at 15, out at 0.
// - Narrow right rotate inserts at bit 31, bit 0 goes out.
// - Narrow left rotate takes bit 31 out, inserts at bit 0.
// - Narrow accumulator rotate clears guard bits 39 to 32.
// - Rotates change only carry and test flag 2.
// - Each rotate step finishes in a single cycle.
// - Rotates repeat correctly, one step per repetition.
// - Rounding adds 8000h and clears the low 16 result bits.
// - Overflow at bit 31 in narrow mode sets the overflow flag.
// - Overflow saturates only when saturation is enabled.
// - Legacy mode keeps the low bits uncleared.
// - Rounding changes only the destination overflow flag.
`timescale 1ns/1ps
// ==========================================================
// Top
module rrd_top
  import rrd_pkg::*;
#(
  parameter int NUM_ACC = 4,
  parameter int NUM_AUX = 4
)(
  // Clock and reset.
  input  wire logic        sys_clk,
  input  wire logic        sys_rst,
  // AHB-Lite slave.
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp
);
  initial
  begin
    if (NUM_ACC < 1 || NUM_ACC > 4 || NUM_AUX < 1 || NUM_AUX > 4)
      $error("rrd_top: register counts must be 1 to 4");
  end

  // ==========================================================
  // Bus state
  logic              take;
  logic              mapped;
  logic              wrPend_r;
  logic              wrPend_nxt;
  logic [ADDR_W-1:0] wrAddr_r;
  logic [ADDR_W-1:0] wrAddr_nxt;
  logic [31:0]       rdData_r;
  logic [31:0]       rdData_nxt;
  logic [31:0]       rdVal;

  // ==========================================================
  // Datapath state
  rrd_state_t        state_r;
  rrd_state_t        state_nxt;
  logic [REP_W-1:0]  cnt_r;
  logic [REP_W-1:0]  cnt_nxt;
  logic [31:0]       cmd_r;
  logic [31:0]       cmd_nxt;
  logic [ACC_W-1:0]  acc_r   [NUM_ACC];
  logic [ACC_W-1:0]  acc_nxt [NUM_ACC];
  logic [AUX_W-1:0]  aux_r   [NUM_AUX];
  logic [AUX_W-1:0]  aux_nxt [NUM_AUX];
  logic [NUM_ACC-1:0] acov_r;
  logic [NUM_ACC-1:0] acov_nxt;
  logic              wide_r;
  logic              wide_nxt;
  logic              rdm_r;
  logic              rdm_nxt;
  logic              sat_r;
  logic              sat_nxt;
  logic              leg_r;
  logic              leg_nxt;
  logic              carry_r;
  logic              carry_nxt;
  logic              tc2_r;
  logic              tc2_nxt;

  // Command fields.
  logic [1:0]        opField;
  logic              isRound;
  logic              isRot;
  logic              srcAux;
  logic              dstAux;
  logic [IDX_W-1:0]  srcIdx;
  logic [IDX_W-1:0]  dstIdx;
  logic [IDX_W-1:0]  rndIdx;
  logic              run;
  logic [ACC_W-1:0]  srcVal;

  rrd_op_if opIf (.clk(sys_clk), .rst(sys_rst));

  rrd_rotator u_rot (.op(opIf.rot));
  rrd_rounder u_rnd (.op(opIf.rnd));

  // ==========================================================
  // Bus port
  // The slave never stretches a transfer and always answers OKAY.
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = rdData_r;
  assign take      = hsel && htrans[1] && hready;
  assign mapped    = haddr[31:ADDR_W] == '0;

  // Read mux over the current register contents.
  always_comb
  begin
    rdVal = '0;
    if (haddr[ADDR_W-1:0] == OFF_CTRL)
    begin
      rdVal[CTRL_WIDE] = wide_r;
      rdVal[CTRL_RDM]  = rdm_r;
      rdVal[CTRL_SAT]  = sat_r;
      rdVal[CTRL_LEG]  = leg_r;
    end
    if (haddr[ADDR_W-1:0] == OFF_FLAGS)
    begin
      rdVal[FLG_CARRY] = carry_r;
      rdVal[FLG_TC2]   = tc2_r;
      rdVal[FLG_ACOV +: NUM_ACC] = acov_r;
      rdVal[FLG_BUSY]  = run;
    end
    if (haddr[ADDR_W-1:0] == OFF_CMD)
    begin
      rdVal = cmd_r;
      rdVal[CMD_REP +: REP_W] = cnt_r;
    end
    for (int i = 0; i < NUM_ACC; i++)
    begin
      if (haddr[ADDR_W-1:0] == 8'(OFF_ACC + i * ACC_STEP))
        rdVal = acc_r[i][ACC_LO_W-1:0];
      if (haddr[ADDR_W-1:0] == 8'(OFF_ACC + i * ACC_STEP + ACC_HI))
        rdVal = 32'(acc_r[i][ACC_W-1:ACC_LO_W]);
    end
    for (int j = 0; j < NUM_AUX; j++)
    begin
      if (haddr[ADDR_W-1:0] == 8'(OFF_AUX + j * AUX_STEP))
        rdVal = 32'(aux_r[j]);
    end
  end

  // Address phase capture; unmapped reads return zero.
  always_comb
  begin
    wrPend_nxt = take && hwrite && mapped;
    wrAddr_nxt = wrAddr_r;
    rdData_nxt = rdData_r;
    if (take)
      wrAddr_nxt = haddr[ADDR_W-1:0];
    if (take && !hwrite)
      rdData_nxt = mapped ? rdVal : '0;
  end

  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      wrPend_r <= 1'b0;
      wrAddr_r <= '0;
      rdData_r <= '0;
    end
    else
    begin
      wrPend_r <= wrPend_nxt;
      wrAddr_r <= wrAddr_nxt;
      rdData_r <= rdData_nxt;
    end
  end

  // ==========================================================
  // Operand selection
  assign opField = cmd_r[CMD_OP +: 2];
  assign isRound = opField == OP_RND;
  assign isRot   = opField == OP_ROR || opField == OP_ROL;
  assign srcAux  = cmd_r[CMD_SRC + IDX_W];
  assign dstAux  = cmd_r[CMD_DST + IDX_W];
  assign srcIdx  = cmd_r[CMD_SRC +: IDX_W];
  assign dstIdx  = cmd_r[CMD_DST +: IDX_W];
  assign run     = state_r == ST_RUN;
  // A missing source makes the destination its own operand.
  assign rndIdx  = cmd_r[CMD_OMIT] ? dstIdx : srcIdx;

  // Fetch the source; register values are zero-extended.
  always_comb
  begin
    srcVal = '0;
    if (srcAux && int'(srcIdx) < NUM_AUX)
      srcVal = ACC_W'(aux_r[srcIdx]);
    else if (!srcAux && int'(srcIdx) < NUM_ACC)
      srcVal = acc_r[srcIdx];
  end

  assign opIf.rotSrc    = srcVal;
  assign opIf.rotAccDst = !dstAux;
  assign opIf.rotLeft   = opField == OP_ROL;
  assign opIf.wide      = wide_r;
  // Either flag may feed the incoming bit.
  assign opIf.inBit     = cmd_r[CMD_IN] ? carry_r : tc2_r;
  assign opIf.rndSrc    = int'(rndIdx) < NUM_ACC ? acc_r[rndIdx] : '0;
  assign opIf.round_mode_bit       = rdm_r;
  assign opIf.sat       = sat_r;
  assign opIf.legacy    = leg_r;

  // ==========================================================
  // Sequencer and register file
  // Writes are refused while an operation runs, so software
  // cannot race the datapath on any flag or operand.
  always_comb
  begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r;
    cmd_nxt   = cmd_r;
    acc_nxt   = acc_r;
    aux_nxt   = aux_r;
    acov_nxt  = acov_r;
    wide_nxt  = wide_r;
    rdm_nxt   = rdm_r;
    sat_nxt   = sat_r;
    leg_nxt   = leg_r;
    carry_nxt = carry_r;
    tc2_nxt   = tc2_r;
    if (wrPend_r && !run)
    begin
      if (wrAddr_r == OFF_CTRL)
      begin
        wide_nxt = hwdata[CTRL_WIDE];
        rdm_nxt  = hwdata[CTRL_RDM];
        sat_nxt  = hwdata[CTRL_SAT];
        leg_nxt  = hwdata[CTRL_LEG];
      end
      if (wrAddr_r == OFF_FLAGS)
      begin
        carry_nxt = hwdata[FLG_CARRY];
        tc2_nxt   = hwdata[FLG_TC2];
        acov_nxt  = hwdata[FLG_ACOV +: NUM_ACC];
      end
      if (wrAddr_r == OFF_CMD)
      begin
        cmd_nxt   = hwdata;
        cnt_nxt   = hwdata[CMD_REP +: REP_W];
        state_nxt = ST_RUN;
      end
      for (int i = 0; i < NUM_ACC; i++)
      begin
        if (wrAddr_r == 8'(OFF_ACC + i * ACC_STEP))
          acc_nxt[i][ACC_LO_W-1:0] = hwdata;
        if (wrAddr_r == 8'(OFF_ACC + i * ACC_STEP + ACC_HI))
          acc_nxt[i][ACC_W-1:ACC_LO_W] = hwdata[ACC_W-ACC_LO_W-1:0];
      end
      for (int j = 0; j < NUM_AUX; j++)
      begin
        if (wrAddr_r == 8'(OFF_AUX + j * AUX_STEP))
          aux_nxt[j] = hwdata[AUX_W-1:0];
      end
    end
    if (run)
    begin
      if (isRound && int'(dstIdx) < NUM_ACC)
      begin
        acc_nxt[dstIdx] = opIf.rndRes;
        if (opIf.rndOvf)
          acov_nxt[dstIdx] = 1'b1;
      end
      if (isRot)
      begin
        if (dstAux && int'(dstIdx) < NUM_AUX)
          aux_nxt[dstIdx] = opIf.rotRes[AUX_W-1:0];
        if (!dstAux && int'(dstIdx) < NUM_ACC)
          acc_nxt[dstIdx] = opIf.rotRes;
        if (cmd_r[CMD_OUT])
          carry_nxt = opIf.outBit;
        else
          tc2_nxt = opIf.outBit;
      end
      // Rounding is never repeated; rotates take one step more than the count.
      if (!isRot || cnt_r == '0)
        state_nxt = ST_IDLE;
      else
        cnt_nxt = cnt_r - 1'b1;
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      state_r <= ST_IDLE;
      cnt_r   <= '0;
      cmd_r   <= '0;
      acc_r   <= '{default: '0};
      aux_r   <= '{default: '0};
      acov_r  <= '0;
      wide_r  <= 1'b0;
      rdm_r   <= 1'b0;
      sat_r   <= 1'b0;
      leg_r   <= 1'b0;
      carry_r <= 1'b0;
      tc2_r   <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
      cmd_r   <= cmd_nxt;
      acc_r   <= acc_nxt;
      aux_r   <= aux_nxt;
      acov_r  <= acov_nxt;
      wide_r  <= wide_nxt;
      rdm_r   <= rdm_nxt;
      sat_r   <= sat_nxt;
      leg_r   <= leg_nxt;
      carry_r <= carry_nxt;
      tc2_r   <= tc2_nxt;
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  sequence s_launch3;
    wrPend_r && !run && wrAddr_r == OFF_CMD
    && hwdata[CMD_OP +: 2] == OP_ROR && hwdata[CMD_REP +: REP_W] == 2;
  endsequence
  sequence s_three_steps;
    run [*3] ##1 !run;
  endsequence

  a_repeat_len: assert property (s_launch3 |=> s_three_steps)
    else $error("repeat count not honoured");
  a_step_single: assert property (run && cnt_r == '0 |=> !run)
    else $error("step took more than one cycle");
  a_flag_route: assert property (run && isRot && cmd_r[CMD_OUT]
    |=> carry_r == $past(opIf.outBit) && tc2_r == $past(tc2_r))
    else $error("outgoing flag misrouted");
  a_round_flags: assert property (run && isRound
    |=> carry_r == $past(carry_r) && tc2_r == $past(tc2_r))
    else $error("rounding touched rotate flags");
  a_ovf_sets: assert property (run && isRound && opIf.rndOvf
    && int'(dstIdx) < NUM_ACC |=> acov_r[$past(dstIdx)])
    else $error("overflow flag not set");
  a_omit_src: assert property (run && isRound && cmd_r[CMD_OMIT]
    && int'(dstIdx) < NUM_ACC |-> opIf.rndSrc == acc_r[dstIdx])
    else $error("omitted source not destination");
endmodule

// File: core/rrd_pkg.sv
// Purpose: Shared constants and types of the rotate and round datapath.
// Assumes: 40-bit accumulators, 16-bit auxiliary registers.
// Notes:   Register offsets are byte addresses on the AHB-Lite port.
// ==========================================================
// Package
package rrd_pkg;
  // Datapath widths.
  localparam int ACC_W    = 40;
  localparam int ACC_LO_W = 32;
  localparam int AUX_W    = 16;
  localparam int NARROW_W = 32;
  localparam int IDX_W    = 2;
  localparam int REP_W    = 8;
  localparam int ADDR_W   = 8;
  // Register offsets.
  localparam logic [7:0] OFF_CTRL  = 8'h00;
  localparam logic [7:0] OFF_FLAGS = 8'h04;
  localparam logic [7:0] OFF_CMD   = 8'h08;
  localparam logic [7:0] OFF_ACC   = 8'h10;
  localparam logic [7:0] ACC_STEP  = 8'h08;
  localparam logic [7:0] ACC_HI    = 8'h04;
  localparam logic [7:0] OFF_AUX   = 8'h30;
  localparam logic [7:0] AUX_STEP  = 8'h04;
  // Field positions.
  localparam int CTRL_WIDE = 0;
  localparam int CTRL_RDM  = 1;
  localparam int CTRL_SAT  = 2;
  localparam int CTRL_LEG  = 3;
  localparam int FLG_CARRY = 0;
  localparam int FLG_TC2   = 1;
  localparam int FLG_ACOV  = 4;
  localparam int FLG_BUSY  = 8;
  localparam int CMD_OP    = 0;
  localparam int CMD_SRC   = 2;
  localparam int CMD_DST   = 5;
  localparam int CMD_IN    = 8;
  localparam int CMD_OUT   = 9;
  localparam int CMD_OMIT  = 10;
  localparam int CMD_REP   = 16;
  // Rounding constant and saturation limits.
  localparam logic [39:0] RND_K   = 40'h0000008000;
  localparam logic [15:0] RND_TIE = 16'h8000;
  localparam logic [39:0] SAT_P40 = 40'h7fffffffff;
  localparam logic [39:0] SAT_N40 = 40'h8000000000;
  localparam logic [39:0] SAT_P32 = 40'h007fffffff;
  localparam logic [39:0] SAT_N32 = 40'hff80000000;
  // Operations and sequencer states.
  typedef enum logic [1:0] {OP_ROR, OP_ROL, OP_RND} rrd_op_t;
  typedef enum logic {ST_IDLE, ST_RUN} rrd_state_t;
endpackage

// File: core/rrd_op_if.sv
// Purpose: Operand and result channel between sequencer and units.
// Assumes: Units are combinational and sample on the shared clock.
// Notes:   Clock and reset ride along for the unit checks.
`timescale 1ns/1ps
// ==========================================================
// Interface
interface rrd_op_if
  import rrd_pkg::*;
(
  input wire logic clk,
  input wire logic rst
);
  logic [ACC_W-1:0] rotSrc;
  logic             rotAccDst;
  logic             rotLeft;
  logic             wide;
  logic             inBit;
  logic [ACC_W-1:0] rotRes;
  logic             outBit;
  logic [ACC_W-1:0] rndSrc;
  logic             round_mode_bit;
  logic             sat;
  logic             legacy;
  logic [ACC_W-1:0] rndRes;
  logic             rndOvf;
  modport ctl (input clk, rst, rotRes, outBit, rndRes, rndOvf,
               output rotSrc, rotAccDst, rotLeft, wide, inBit,
               rndSrc, round_mode_bit, sat, legacy);
  modport rot (input clk, rst, rotSrc, rotAccDst, rotLeft, wide,
               inBit, output rotRes, outBit);
  modport rnd (input clk, rst, rndSrc, wide, round_mode_bit, sat, legacy,
               output rndRes, rndOvf);
endinterface

// File: core/rrd_rotator.sv
// Purpose: One-bit rotate through a flag, accumulator or 16-bit path.
// Assumes: Source already zero-extended by the sequencer.
// Notes:   Purely combinational; guard bits cleared in narrow mode.
`timescale 1ns/1ps
// ==========================================================
// Rotator
module rrd_rotator
  import rrd_pkg::*;
(
  // Operand channel.
  rrd_op_if.rot op
);
  // Pick the data width from destination and wide mode.
  always_comb
  begin
    op.rotRes = '0;
    op.outBit = 1'b0;
    if (!op.rotAccDst)
    begin
      if (op.rotLeft)
      begin
        op.rotRes[AUX_W-1:0] = {op.rotSrc[AUX_W-2:0], op.inBit};
        op.outBit = op.rotSrc[AUX_W-1];
      end
      else
      begin
        op.rotRes[AUX_W-1:0] = {op.inBit, op.rotSrc[AUX_W-1:1]};
        op.outBit = op.rotSrc[0];
      end
    end
    else if (op.wide)
    begin
      if (op.rotLeft)
      begin
        op.rotRes = {op.rotSrc[ACC_W-2:0], op.inBit};
        op.outBit = op.rotSrc[ACC_W-1];
      end
      else
      begin
        op.rotRes = {op.inBit, op.rotSrc[ACC_W-1:1]};
        op.outBit = op.rotSrc[0];
      end
    end
    else
    begin
      // Upper bits stay zero, which clears the guard byte.
      if (op.rotLeft)
      begin
        op.rotRes[NARROW_W-1:0] = {op.rotSrc[NARROW_W-2:0], op.inBit};
        op.outBit = op.rotSrc[NARROW_W-1];
      end
      else
      begin
        op.rotRes[NARROW_W-1:0] = {op.inBit, op.rotSrc[NARROW_W-1:1]};
        op.outBit = op.rotSrc[0];
      end
    end
  end

  default clocking cb @(posedge op.clk); endclocking
  default disable iff (op.rst);
  // Narrow right rotate lands the input at bit 31 with clear guards.
  a_ror_narrow: assert property (op.rotAccDst && !op.wide && !op.rotLeft
    |-> op.rotRes[ACC_W-1:NARROW_W] == '0 && op.rotRes[31] == op.inBit
    && op.outBit == op.rotSrc[0]) else $error("narrow ror wrong");
  a_rol_narrow: assert property (op.rotAccDst && !op.wide && op.rotLeft
    |-> op.outBit == op.rotSrc[31] && op.rotRes[0] == op.inBit
    && op.rotRes[ACC_W-1:NARROW_W] == '0) else $error("narrow rol");
  a_wide_ends: assert property (op.rotAccDst && op.wide
    |-> (op.rotLeft ? op.outBit == op.rotSrc[39]
                    : op.rotRes[39] == op.inBit))
    else $error("wide rotate end bit wrong");
  a_aux_ends: assert property (!op.rotAccDst && !op.rotLeft
    |-> op.rotRes[15] == op.inBit && op.rotRes[ACC_W-1:AUX_W] == '0)
    else $error("16-bit rotate wrong");
endmodule

// File: core/rrd_rounder.sv
// Purpose: Accumulator rounding with overflow detect and saturation.
// Assumes: Source is a 40-bit accumulator value.
// Notes:   Round-to-even on ties when round mode is set.
`timescale 1ns/1ps
// ==========================================================
// Rounder
module rrd_rounder
  import rrd_pkg::*;
(
  // Operand channel.
  rrd_op_if.rnd op
);
  logic [ACC_W-1:0] sum;

  // Add the constant, fix ties, detect overflow, then saturate.
  always_comb
  begin
    sum = op.rndSrc + RND_K;
    if (op.round_mode_bit && op.rndSrc[AUX_W-1:0] == RND_TIE)
      sum[AUX_W] = 1'b0;
    if (op.wide)
      op.rndOvf = !op.rndSrc[ACC_W-1] && sum[ACC_W-1];
    else
      op.rndOvf = sum[ACC_W-1:NARROW_W-1] != '0
               && sum[ACC_W-1:NARROW_W-1] != '1;
    op.rndRes = sum;
    if (!op.legacy)
      op.rndRes[AUX_W-1:0] = '0;
    if (op.rndOvf && op.sat)
    begin
      if (op.wide)
        op.rndRes = op.rndSrc[ACC_W-1] ? SAT_N40 : SAT_P40;
      else
        op.rndRes = op.rndSrc[ACC_W-1] ? SAT_N32 : SAT_P32;
    end
  end

  default clocking cb @(posedge op.clk); endclocking
  default disable iff (op.rst);
  a_clear_low: assert property (!op.legacy && !op.rndOvf
    |-> op.rndRes[15:0] == '0) else $error("low bits kept");
  a_sat_value: assert property (op.rndOvf && op.sat && !op.wide
    |-> op.rndRes == SAT_P32 || op.rndRes == SAT_N32)
    else $error("no saturation");
  a_wrap_kept: assert property (op.rndOvf && !op.sat
    |-> op.rndRes[39:16] == sum[39:16])
    else $error("wrapped value lost");
endmodule

// File: tb/rotate_round_datapath_bench.sv
// Purpose: Self-checking bench for the rotate and round datapath.
// Assumes: Zero-wait AHB-Lite slave, four accumulators, four aux regs.
// Notes:   Rotate loop and repeat test expected values come from a small rotate model in this file; the others are literals.
`timescale 1ns/1ps
`define CHK(nm, e, g) \
  begin \
    nCompared++; \
    if ((g) !== (e)) \
    begin \
      numErrors++; \
      $display("Error %s expected %h seen %h", nm, e, g); \
    end \
  end
// ==========================================================
// Bench
module rotate_round_datapath_bench
  import rrd_pkg::*;
;
  logic        sys_clk;
  logic        sys_rst;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  wire logic   hready;
  logic        hresp;
  int          numErrors;
  int          nCompared;
  int          cycles;

  // The slave's ready output is the bus ready, as on a one-slave bus.
  rrd_top u_rrd_top (
    .sys_clk   (sys_clk),
    .sys_rst   (sys_rst),
    .hsel      (hsel),
    .haddr     (haddr),
    .htrans    (htrans),
    .hwrite    (hwrite),
    .hsize     (hsize),
    .hwdata    (hwdata),
    .hready    (hready),
    .hrdata    (hrdata),
    .hreadyout (hready),
    .hresp     (hresp)
  );

  // Free-running 25 MHz clock.
  initial
  begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  // A hung handshake ends the run here rather than in the tool.
  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      numErrors++;
      conclude();
    end
  end

  // ==========================================================
  // Bus tasks
  task automatic busWait();
    @(posedge sys_clk);
    while (hready !== 1'b1) @(posedge sys_clk);
  endtask

  task automatic addrPhase(input logic [31:0] a, input logic w);
    @(posedge sys_clk);
    hsel   <= 1'b1;
    haddr  <= a;
    hwrite <= w;
    htrans <= 2'b10;
    busWait();
    htrans <= 2'b00;
  endtask

  task automatic ahbWr(input logic [31:0] a, input logic [31:0] d);
    addrPhase(a, 1'b1);
    hwdata <= d;
    busWait();
  endtask

  task automatic ahbRd(input logic [31:0] a, output logic [31:0] d);
    addrPhase(a, 1'b0);
    busWait();
    d = hrdata;
  endtask

  function automatic logic [31:0] accAddr(int i);
    return 32'(OFF_ACC) + 32'(i) * 32'(ACC_STEP);
  endfunction

  task automatic setAcc(input int i, input logic [39:0] v);
    ahbWr(accAddr(i), v[31:0]);
    ahbWr(accAddr(i) + 32'(ACC_HI), {24'h0, v[39:32]});
  endtask

  task automatic getAcc(input int i, output logic [39:0] v);
    logic [31:0] lo;
    logic [31:0] hi;
    ahbRd(accAddr(i), lo);
    ahbRd(accAddr(i) + 32'(ACC_HI), hi);
    v = {hi[7:0], lo};
  endtask

  function automatic logic [31:0] cmd(logic [1:0] op, logic [2:0] s,
      logic [2:0] d, logic i, logic o, logic om, logic [7:0] rep);
    return 32'(op) << CMD_OP | 32'(s) << CMD_SRC | 32'(d) << CMD_DST
         | 32'(i) << CMD_IN | 32'(o) << CMD_OUT | 32'(om) << CMD_OMIT
         | 32'(rep) << CMD_REP;
  endfunction

  // Writes are lost while busy, so every command waits for idle.
  task automatic runCmd(input logic [31:0] c);
    logic [31:0] f;
    ahbWr(32'(OFF_CMD), c);
    f = 32'h100;
    for (int k = 0; k < 40 && f[FLG_BUSY] !== 1'b0; k++)
      ahbRd(32'(OFF_FLAGS), f);
    `CHK("busy", 1'b0, f[FLG_BUSY])
  endtask

  // Returns the outgoing bit above the 40-bit rotated value.
  function automatic logic [40:0] rotM(logic [39:0] v, logic l,
      logic w, logic b);
    if (!l && w) return {v[0], b, v[39:1]};
    if (!l) return {v[0], 8'h00, b, v[31:1]};
    if (w) return {v[39], v[38:0], b};
    return {v[31], 8'h00, v[30:0], b};
  endfunction

  // Rounds acc0 into acc1, or acc3 in place when the source is omitted.
  task automatic rnd(input logic [3:0] c, input logic [39:0] s,
      input logic o, input logic [39:0] ex, input logic [31:0] ef);
    logic [39:0] v;
    logic [31:0] f;
    ahbWr(32'(OFF_CTRL), 32'(c));
    ahbWr(32'(OFF_FLAGS), 32'h3);
    setAcc(o ? 3 : 0, s);
    runCmd(cmd(OP_RND, 3'd0, o ? 3'd3 : 3'd1, 1'b0, 1'b0, o, 8'h0));
    getAcc(o ? 3 : 1, v);
    `CHK("round acc", ex, v)
    ahbRd(32'(OFF_FLAGS), f);
    `CHK("round flags", ef, f)
  endtask

  task automatic conclude();
    if (numErrors == 0 && nCompared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // ==========================================================
  // Main sequence
  initial
  begin
    logic [39:0] a;
    logic [39:0] e;
    logic [40:0] m;
    logic [31:0] r;
    logic [1:0]  fl;
    logic        b;
    numErrors = 0;
    nCompared = 0;
    cycles    = 0;
    sys_rst   = 1'b1;
    hsel      = 1'b0;
    haddr     = 32'h0;
    htrans    = 2'b00;
    hwrite    = 1'b0;
    hsize     = 3'b010;
    hwdata    = 32'h0;
    repeat (8) @(posedge sys_clk);
    sys_rst <= 1'b0;
    ahbRd(32'(OFF_FLAGS), r);
    `CHK("reset flags", 32'h0, r)
    // Narrow right rotate through test flag 2 into another accumulator.
    setAcc(0, 40'h5fb0001234);
    ahbWr(32'(OFF_FLAGS), 32'h2);
    runCmd(cmd(OP_ROR, 3'd0, 3'd1, 1'b0, 1'b0, 1'b0, 8'h0));
    getAcc(1, a);
    `CHK("ror acc1", 40'h00d800091a, a)
    ahbRd(32'(OFF_FLAGS), r);
    `CHK("ror flags", 32'h0, r)
    // Both directions, both widths, every flag pairing.
    for (int k = 0; k < 16; k++)
    begin
      e  = 40'h8123456789 ^ 40'(k);
      fl = 2'(k * 3);
      ahbWr(32'(OFF_CTRL), 32'(k[1]));
      setAcc(2, e);
      ahbWr(32'(OFF_FLAGS), {24'h0, 4'ha, 2'b00, fl});
      b = k[2] ? fl[FLG_CARRY] : fl[FLG_TC2];
      m = rotM(e, k[0], k[1], b);
      if (k[3]) fl[FLG_CARRY] = m[40];
      else fl[FLG_TC2] = m[40];
      runCmd(cmd(2'(k[0]), 3'd2, 3'd2, k[2], k[3], 1'b0, 8'h0));
      getAcc(2, a);
      `CHK("rot acc", m[39:0], a)
      ahbRd(32'(OFF_FLAGS), r);
      `CHK("rot flags", {24'h0, 4'ha, 2'b00, fl}, r)
    end
    // A 16-bit source is widened with zeros before a wide left rotate.
    ahbWr(32'(OFF_AUX), 32'hffffb00f);
    ahbWr(32'(OFF_FLAGS), 32'h1);
    runCmd(cmd(OP_ROL, 3'b100, 3'd3, 1'b1, 1'b1, 1'b0, 8'h0));
    getAcc(3, a);
    `CHK("aux to acc", 40'h000001601f, a)
    // Register destinations work on the low 16 bits only.
    setAcc(2, 40'hffffff8001);
    runCmd(cmd(OP_ROR, 3'd2, 3'b101, 1'b1, 1'b0, 1'b0, 8'h0));
    ahbRd(32'(OFF_AUX) + 32'(AUX_STEP), r);
    `CHK("ror aux1", 32'h00004000, r)
    runCmd(cmd(OP_ROL, 3'b101, 3'b101, 1'b0, 1'b1, 1'b0, 8'h0));
    ahbRd(32'(OFF_AUX) + 32'(AUX_STEP), r);
    `CHK("rol aux1", 32'h00008001, r)
    ahbRd(32'(OFF_FLAGS), r);
    `CHK("aux flags", 32'h2, r)
    // Three repetitions of a narrow right rotate in place.
    ahbWr(32'(OFF_CTRL), 32'h0);
    ahbWr(32'(OFF_FLAGS), 32'h0);
    e = 40'h5fb0001234;
    b = 1'b0;
    for (int k = 0; k < 3; k++)
    begin
      m = rotM(e, 1'b0, 1'b0, b);
      e = m[39:0];
      b = m[40];
    end
    runCmd(cmd(OP_ROR, 3'd0, 3'd0, 1'b1, 1'b1, 1'b0, 8'd2));
    getAcc(0, a);
    `CHK("repeat acc0", e, a)
    ahbRd(32'(OFF_CMD), r);
    `CHK("repeat left", 8'h00, r[23:16])
    // A control write landing while busy must be dropped.
    ahbWr(32'(OFF_CMD), cmd(OP_ROR, 3'd3, 3'd3, 1'b0, 1'b0, 1'b0, 8'd5));
    ahbWr(32'(OFF_CTRL), 32'h1);
    // Let the long rotate drain so that the idle command really lands.
    repeat (8) @(posedge sys_clk);
    runCmd(32'h3);
    ahbRd(32'(OFF_CTRL), r);
    `CHK("busy write", 32'h0, r)
    // Rounding: plain, saturated, legacy, omitted source with a tie.
    rnd(4'h2, 40'hef0ff08023, 1'b0, 40'hef0ff10000, 32'h23);
    rnd(4'h6, 40'hef0ff08023, 1'b0, 40'hff80000000, 32'h23);
    rnd(4'h8, 40'hef0ff08023, 1'b0, 40'hef0ff10023, 32'h23);
    rnd(4'h3, 40'h0000008000, 1'b1, 40'h0, 32'h03);
    // Unmapped places read zero and ignore writes.
    ahbWr(32'h00000100, 32'hffffffff);
    ahbRd(32'h00000100, r);
    `CHK("unmapped hi", 32'h0, r)
    ahbRd(32'h0000000c, r);
    `CHK("unmapped 0c", 32'h0, r)
    `CHK("hresp", 1'b0, hresp)
    conclude();
  end
endmodule
